// File: design/tpse_defs.vh
// constants for the three-phase sine pwm engine
`ifndef TPSE_DEFS_VH
`define TPSE_DEFS_VH

`define TPSE_DEAD_OFFSET 8'h0A
`define TPSE_SINE_MID 9'h073
`define TPSE_SHIFT_S 8'h55
`define TPSE_SHIFT_T 8'hAB
`define TPSE_AMP_MAX 8'h40
`define TPSE_BUILD_LAST 10'h2FF
`define TPSE_RST_AMP 8'h40
`define TPSE_RST_STEP 8'h01
`define TPSE_PWM_PERIOD_NS 64'h0000_C350
`define TPSE_MIN_FREQ_HZ 64'h0000_0001
`define TPSE_MIN_DELTA ((64'h0001_0000 * `TPSE_PWM_PERIOD_NS * `TPSE_MIN_FREQ_HZ \
    + 64'h3B9A_C9FF) / 64'h3B9A_CA00)

`define TPSE_CMD_ID 8'h80
`define TPSE_CMD_GET_FREQ 8'h81
`define TPSE_CMD_GET_AMP 8'h82
`define TPSE_CMD_SET_CW 8'hC0
`define TPSE_CMD_SET_CCW 8'hC1
`define TPSE_CMD_SET_AMP 8'hC2
`define TPSE_CMD_SET_UP 8'hC3
`define TPSE_CMD_SET_DOWN 8'hC4
`define TPSE_CMD_SET_DIR 8'hC5

// quarter-wave source decimated by four, entry k in bits 8k+7..8k
`define TPSE_QSINE {192'h7373_7373_7272_7271_7070_6F6E_6E6D_6C6B_6A68_6766_6563_6260, \
    256'h5F5D_5B59_5856_5452_504E_4C49_4745_4340_3E3C_3937_3432_2F2C_2A27_2422_1F1C_1917, \
    64'h1411_0E0B_0906_0300}
// arccos offset for amplitude 0..64, entry a in bits 8a+7..8a
`define TPSE_ACOS {184'h00_070A_0C0E_1012_1315_1617_1819_1A1B_1C1D_1E1F_2021_2223, \
    256'h2424_2526_2728_2829_2A2B_2B2C_2D2E_2E2F_3030_3132_3233_3434_3536_3637_3838_393A, \
    80'h3A3B_3C3C_3D3D_3E3F_3F40}

`endif

// File: design/tpse_engine.v
// three-phase sine pwm engine: tables, ramp, trap and byte commands
`timescale 1ns/1ps
`include "tpse_defs.vh"
module tpse_engine #(
    parameter [7:0] ID_CODE = 8'hA5 // arbitrary identification value
) (
    input wire CLK,
    input wire NRST,
    input wire UPDATE_TICK,
    input wire RX_VALID,
    input wire [7:0] RX_DATA,
    input wire TX_READY,
    output wire TX_VALID,
    output wire [7:0] TX_DATA,
    input wire ESTOP,
    input wire [7:0] RAMP_INTERVAL,
    input wire TRAP_INPUT_N,
    input wire [5:0] TRAP_ENABLE_REG,
    input wire [2:0] TRAP_LEVEL_REG,
    input wire [2:0] PWM_PHASE_IN,
    input wire [2:0] PWM_COMPLEMENT_IN,
    output wire [2:0] PWM_PHASE_OUT,
    output wire [2:0] PWM_COMPLEMENT_OUT,
    output wire [7:0] CMP_U,
    output wire [7:0] CMP_V,
    output wire [7:0] CMP_W,
    output wire CMP_LOAD,
    output wire OUTPUTS_ON,
    output wire TRAP_ACTIVE,
    output wire TABLE_READY
);
    // ---------------------------------------------------------------
    // constants and lookup function
    // ---------------------------------------------------------------
    localparam [511:0] QSINE = `TPSE_QSINE;
    localparam [519:0] ACOS = `TPSE_ACOS;
    localparam [1:0] ST_IDLE = 2'b00, ST_ARG = 2'b01, ST_REPLY = 2'b10;

    // full-period sample from the quarter-wave source
    function [7:0] wave;
        input [7:0] p;
        reg [5:0] k;
        reg [8:0] mag;
        reg [8:0] s;
        begin
            k = p[6] ? ~p[5:0] : p[5:0];
            mag = {1'b0, QSINE[8*k +: 8]};
            s = p[7] ? (`TPSE_SINE_MID - mag) : (`TPSE_SINE_MID + mag);
            wave = s[8:1] + `TPSE_DEAD_OFFSET;
        end
    endfunction

    wire [63:0] min_delta_full = `TPSE_MIN_DELTA;
    wire [15:0] min_delta = min_delta_full[15:0];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [9:0] build_idx_reg;
    reg [15:0] acc_reg, delta_reg, target_reg, new_cmp_reg;
    reg [7:0] amp_reg, up_reg, down_reg, ramp_cnt_reg, aprime_reg, first_reg;
    reg [7:0] cmp_u_reg, cmp_v_reg, cmp_w_reg, rx_hold_reg, cmd_reg, arg_lo_reg;
    reg built_reg, dir_reg, dir_req_reg, cmp_load_reg;
    reg out_on_reg, rx_full_reg, arg_cnt_reg;
    reg trap_meta_reg, trap_sync_reg, trap_latched_reg;
    reg [2:0] rd_step_reg;
    reg [5:0] pwm_out_reg;
    reg [1:0] st_reg, reply_cnt_reg;
    reg [23:0] reply_sh_reg;
    wire [7:0] ram_q;

    // ---------------------------------------------------------------
    // table build after reset
    // ---------------------------------------------------------------
    wire [1:0] build_tbl = build_idx_reg[9:8];
    wire [7:0] build_shift = (build_tbl == 2'd1) ? `TPSE_SHIFT_S :
                             (build_tbl == 2'd2) ? `TPSE_SHIFT_T : 8'h00;
    wire [7:0] build_pos = build_idx_reg[7:0] + build_shift;
    wire [7:0] build_data = wave(build_pos);

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            build_idx_reg <= 10'h000;
            built_reg <= 1'b0;
        end else if (!built_reg) begin
            if (build_idx_reg == `TPSE_BUILD_LAST) begin
                built_reg <= 1'b1;
            end else begin
                build_idx_reg <= build_idx_reg + 10'h001;
            end
        end
    end

    // ---------------------------------------------------------------
    // compare update sequence
    // ---------------------------------------------------------------
    wire start = UPDATE_TICK && built_reg && (rd_step_reg == 3'd0);
    wire [2:0] rd_idx = rd_step_reg - 3'd1;
    wire [1:0] rd_ch = rd_idx[2:1];
    // counterclockwise swaps the second and third phase
    wire [1:0] rd_tbl = (dir_reg && rd_ch != 2'd0) ? (2'd3 - rd_ch) : rd_ch;
    wire [7:0] ptr = acc_reg[15:8];
    wire [7:0] rd_pos = rd_idx[0] ? (ptr + aprime_reg) : (ptr - aprime_reg);
    wire [9:0] rd_addr = {rd_tbl, rd_pos};
    wire [2:0] cap_idx = rd_step_reg - 3'd2;
    wire [7:0] cap_sum = first_reg + ram_q;
    wire [6:0] amp_idx = amp_reg[6:0];

    tpse_table_ram #(
        .AW(10),
        .DW(8)
    ) u_ram (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(!built_reg),
        .wr_addr(build_idx_reg),
        .wr_data(build_data),
        .rd_addr(rd_addr),
        .rd_data(ram_q)
    );

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rd_step_reg <= 3'd0;
            aprime_reg <= 8'h00;
            first_reg <= 8'h00;
            new_cmp_reg <= 16'h0000;
            cmp_u_reg <= 8'h00;
            cmp_v_reg <= 8'h00;
            cmp_w_reg <= 8'h00;
            cmp_load_reg <= 1'b0;
        end else begin
            cmp_load_reg <= 1'b0;
            if (start) begin
                aprime_reg <= ACOS[8*amp_idx +: 8];
                rd_step_reg <= 3'd1;
            end else if (rd_step_reg != 3'd0) begin
                rd_step_reg <= (rd_step_reg == 3'd7) ? 3'd0 : rd_step_reg + 3'd1;
            end
            if (rd_step_reg >= 3'd2) begin
                if (!cap_idx[0]) begin
                    first_reg <= ram_q;
                end else if (cap_idx[2:1] == 2'd0) begin
                    new_cmp_reg[7:0] <= cap_sum;
                end else if (cap_idx[2:1] == 2'd1) begin
                    new_cmp_reg[15:8] <= cap_sum;
                end else begin
                    // all three channels load together
                    cmp_u_reg <= new_cmp_reg[7:0];
                    cmp_v_reg <= new_cmp_reg[15:8];
                    cmp_w_reg <= cap_sum;
                    cmp_load_reg <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // phase accumulator, ramp and direction
    // ---------------------------------------------------------------
    // a pending reversal first ramps to zero
    wire [15:0] eff_target = (dir_req_reg != dir_reg) ? 16'h0000 : target_reg;
    wire [16:0] up_sum = {1'b0, delta_reg} + {9'h000, up_reg};
    wire [15:0] up_val = (up_sum > {1'b0, eff_target}) ? eff_target : up_sum[15:0];
    wire [15:0] gap = delta_reg - eff_target;
    wire [15:0] dn_val = (gap <= {8'h00, down_reg}) ? eff_target
                                                    : delta_reg - {8'h00, down_reg};
    wire ramp_due = ramp_cnt_reg >= RAMP_INTERVAL;

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            acc_reg <= 16'h0000;
            delta_reg <= 16'h0000;
            ramp_cnt_reg <= 8'h00;
            dir_reg <= 1'b0;
        end else begin
            if (start) begin
                acc_reg <= acc_reg + delta_reg;
                if (ramp_due) begin
                    ramp_cnt_reg <= 8'h00;
                    if (delta_reg < eff_target) begin
                        delta_reg <= up_val;
                    end else if (delta_reg > eff_target) begin
                        delta_reg <= dn_val;
                    end
                end else begin
                    ramp_cnt_reg <= ramp_cnt_reg + 8'h01;
                end
            end
            if (delta_reg == 16'h0000 && dir_req_reg != dir_reg) begin
                dir_reg <= dir_req_reg;
            end
            if (ESTOP) begin
                delta_reg <= 16'h0000;
            end
        end
    end

    // ---------------------------------------------------------------
    // trap input and output gating
    // ---------------------------------------------------------------
    wire run_on = built_reg && (delta_reg >= min_delta);
    wire trap_hit = trap_latched_reg || !trap_sync_reg;
    wire [5:0] pwm_in = {PWM_COMPLEMENT_IN, PWM_PHASE_IN};
    wire [5:0] pwm_next;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_out
            // both sides of a phase share one trap level
            assign pwm_next[gi] = (trap_hit && TRAP_ENABLE_REG[gi])
                                  ? TRAP_LEVEL_REG[gi % 3]
                                  : (run_on ? pwm_in[gi] : 1'b0);
        end
    endgenerate

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            trap_meta_reg <= 1'b1;
            trap_sync_reg <= 1'b1;
            trap_latched_reg <= 1'b0;
            out_on_reg <= 1'b0;
            pwm_out_reg <= 6'h00;
        end else begin
            trap_meta_reg <= TRAP_INPUT_N;
            trap_sync_reg <= trap_meta_reg;
            if (!trap_sync_reg) begin
                trap_latched_reg <= 1'b1;
            end
            out_on_reg <= run_on;
            pwm_out_reg <= pwm_next;
        end
    end

    // ---------------------------------------------------------------
    // receive path
    // ---------------------------------------------------------------
    wire take = rx_full_reg && (st_reg != ST_REPLY);

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rx_hold_reg <= 8'h00;
            rx_full_reg <= 1'b0;
        end else begin
            if (RX_VALID) begin
                rx_hold_reg <= RX_DATA;
            end
            rx_full_reg <= RX_VALID || (rx_full_reg && !take);
        end
    end

    // ---------------------------------------------------------------
    // command loop
    // ---------------------------------------------------------------
    wire [7:0] amp_clip = (rx_hold_reg > `TPSE_AMP_MAX) ? `TPSE_AMP_MAX : rx_hold_reg;

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_reg <= ST_IDLE;
            cmd_reg <= 8'h00;
            arg_cnt_reg <= 1'b0;
            arg_lo_reg <= 8'h00;
            reply_sh_reg <= 24'h00_0000;
            reply_cnt_reg <= 2'd0;
            target_reg <= 16'h0000;
            dir_req_reg <= 1'b0;
            amp_reg <= `TPSE_RST_AMP;
            up_reg <= `TPSE_RST_STEP;
            down_reg <= `TPSE_RST_STEP;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (take) begin
                        case (rx_hold_reg)
                            `TPSE_CMD_ID: begin
                                reply_sh_reg <= {16'h0000, ID_CODE};
                                reply_cnt_reg <= 2'd1;
                                st_reg <= ST_REPLY;
                            end
                            `TPSE_CMD_GET_FREQ: begin
                                reply_sh_reg <= {7'h00, dir_reg, delta_reg};
                                reply_cnt_reg <= 2'd3;
                                st_reg <= ST_REPLY;
                            end
                            `TPSE_CMD_GET_AMP: begin
                                reply_sh_reg <= {16'h0000, amp_reg};
                                reply_cnt_reg <= 2'd1;
                                st_reg <= ST_REPLY;
                            end
                            `TPSE_CMD_SET_CW, `TPSE_CMD_SET_CCW, `TPSE_CMD_SET_AMP,
                            `TPSE_CMD_SET_UP, `TPSE_CMD_SET_DOWN,
                            `TPSE_CMD_SET_DIR: begin
                                cmd_reg <= rx_hold_reg;
                                arg_cnt_reg <= 1'b0;
                                st_reg <= ST_ARG;
                            end
                            default: begin
                                st_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ARG: begin
                    if (take) begin
                        if ((cmd_reg == `TPSE_CMD_SET_CW || cmd_reg == `TPSE_CMD_SET_CCW)
                            && !arg_cnt_reg) begin
                            arg_lo_reg <= rx_hold_reg;
                            arg_cnt_reg <= 1'b1;
                        end else begin
                            st_reg <= ST_IDLE;
                            case (cmd_reg)
                                `TPSE_CMD_SET_CW: begin
                                    target_reg <= {rx_hold_reg, arg_lo_reg};
                                    dir_req_reg <= 1'b0;
                                end
                                `TPSE_CMD_SET_CCW: begin
                                    target_reg <= {rx_hold_reg, arg_lo_reg};
                                    dir_req_reg <= 1'b1;
                                end
                                `TPSE_CMD_SET_AMP: amp_reg <= amp_clip;
                                `TPSE_CMD_SET_UP: up_reg <= rx_hold_reg;
                                `TPSE_CMD_SET_DOWN: down_reg <= rx_hold_reg;
                                `TPSE_CMD_SET_DIR: dir_req_reg <= rx_hold_reg[0];
                                default: st_reg <= ST_IDLE;
                            endcase
                        end
                    end
                end
                ST_REPLY: begin
                    if (TX_READY) begin
                        reply_sh_reg <= {8'h00, reply_sh_reg[23:8]};
                        reply_cnt_reg <= reply_cnt_reg - 2'd1;
                        if (reply_cnt_reg == 2'd1) begin
                            st_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
            if (ESTOP) begin
                target_reg <= 16'h0000;
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign TX_VALID = (st_reg == ST_REPLY);
    assign TX_DATA = reply_sh_reg[7:0];
    assign PWM_PHASE_OUT = pwm_out_reg[2:0];
    assign PWM_COMPLEMENT_OUT = pwm_out_reg[5:3];
    assign CMP_U = cmp_u_reg;
    assign CMP_V = cmp_v_reg;
    assign CMP_W = cmp_w_reg;
    assign CMP_LOAD = cmp_load_reg;
    assign OUTPUTS_ON = out_on_reg;
    assign TRAP_ACTIVE = trap_latched_reg;
    assign TABLE_READY = built_reg;
endmodule

// File: design/tpse_table_ram.v
// waveform table memory with registered read data
`timescale 1ns/1ps
module tpse_table_ram #(
    parameter AW = 10,
    parameter DW = 8
) (
    input wire clk,
    input wire nrst,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= {DW{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// File: tb/tb_tpse_engine.sv
// self-checking testbench for the three-phase sine pwm engine
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
$display("Error %s expected %h seen %h", n, e, s); end end
module tb_tpse_engine;
    localparam logic [7:0] ID = 8'h3C; // arbitrary identification value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic tick = 1'b0;
    logic estop = 1'b0;
    logic trap_n = 1'b1;
    logic [7:0] ramp = 8'h00;
    logic [5:0] tr_en = 6'h0D;
    logic [2:0] tr_lvl = 3'h3;
    logic [2:0] ph_in = 3'h6;
    logic [2:0] co_in = 3'h4;
    wire rx_v, tx_rdy, tx_v, load, on, tact, rdy;
    wire [7:0] rx_d, tx_d, cu, cv, cw;
    wire [2:0] ph_out, co_out;
    logic [7:0] b0, b1, b2, u0;
    int bad_count = 0;
    int n_compared = 0;
    always #50 clk = ~clk;
    tpse_engine #(.ID_CODE(ID)) tpse_engine_i (
        .CLK(clk), .NRST(nrst), .UPDATE_TICK(tick), .RX_VALID(rx_v), .RX_DATA(rx_d),
        .TX_READY(tx_rdy), .TX_VALID(tx_v), .TX_DATA(tx_d), .ESTOP(estop),
        .RAMP_INTERVAL(ramp), .TRAP_INPUT_N(trap_n), .TRAP_ENABLE_REG(tr_en),
        .TRAP_LEVEL_REG(tr_lvl), .PWM_PHASE_IN(ph_in), .PWM_COMPLEMENT_IN(co_in),
        .PWM_PHASE_OUT(ph_out), .PWM_COMPLEMENT_OUT(co_out), .CMP_U(cu), .CMP_V(cv),
        .CMP_W(cw), .CMP_LOAD(load), .OUTPUTS_ON(on), .TRAP_ACTIVE(tact), .TABLE_READY(rdy));
    tpse_host tpse_host_i (.CLK(clk), .RX_VALID(rx_v), .RX_DATA(rx_d), .TX_READY(tx_rdy),
        .TX_VALID(tx_v), .TX_DATA(tx_d));
    task summarize;
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task do_reset;
        int n;
        n = 0;
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rdy !== 1'b1 && n < 900);
        `CHK("build cycles", 768, n)
        `CHK("trap flag", 1'b0, tact)
    endtask
    task query(input logic [7:0] c);
        tpse_host_i.send(c);
        tpse_host_i.recv(b0);
        if (c == 8'h81) begin
            tpse_host_i.recv(b1);
            tpse_host_i.recv(b2);
        end
    endtask
    task ticks(input int k);
        repeat (k) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (12) @(posedge clk);
        end
    endtask
    task freq_is(input logic [15:0] inc, input logic [7:0] dir);
        query(8'h81);
        `CHK("increment", inc, {b1, b0})
        `CHK("direction", dir, b2)
    endtask
    task t_query;
        tpse_host_i.lag = 3;
        query(8'h80);
        `CHK("id byte", ID, b0)
        tpse_host_i.lag = 0;
        query(8'h82);
        `CHK("amplitude", 8'h40, b0)
        freq_is(16'h0000, 8'h00);
        ticks(1);
        `CHK("compare u", 8'h86, cu)
        `CHK("compare v", 8'hEA, cv)
        `CHK("compare w", 8'h22, cw)
    endtask
    task t_set;
        tpse_host_i.cmd(8'hC2, 1, 16'h0020);
        query(8'h82);
        `CHK("amplitude set", 8'h20, b0)
        tpse_host_i.cmd(8'hC2, 1, 16'h0050);
        tpse_host_i.send(8'h55);
        query(8'h82);
        `CHK("amplitude clip", 8'h40, b0)
    endtask
    task t_ramp;
        tpse_host_i.cmd(8'hC3, 1, 16'h0003);
        tpse_host_i.cmd(8'hC0, 2, 16'h0010);
        ticks(1);
        freq_is(16'h0003, 8'h00);
        `CHK("below minimum", 1'b0, on)
        ticks(1);
        `CHK("outputs on", 1'b1, on)
        `CHK("phase pass", ph_in, ph_out)
        ticks(4);
        freq_is(16'h0010, 8'h00);
        ramp <= 8'h02;
        tpse_host_i.cmd(8'hC4, 1, 16'h0005);
        tpse_host_i.cmd(8'hC0, 2, 16'h0000);
        ticks(2);
        freq_is(16'h0010, 8'h00);
        ticks(1);
        freq_is(16'h000B, 8'h00);
    endtask
    task t_dir;
        ramp <= 8'h00;
        tpse_host_i.cmd(8'hC5, 1, 16'h0001);
        ticks(6);
        freq_is(16'h0000, 8'h01);
        `CHK("off at zero", 1'b0, on)
        `CHK("phase off", 3'h0, ph_out)
        tpse_host_i.cmd(8'hC1, 2, 16'h0008);
        ticks(3);
        freq_is(16'h0008, 8'h01);
    endtask
    task t_stop;
        @(posedge clk);
        estop <= 1'b1;
        @(posedge clk);
        estop <= 1'b0;
        query(8'h81);
        `CHK("stop increment", 16'h0000, {b1, b0})
        ticks(1);
        u0 = cu;
        ticks(1);
        `CHK("frozen compare", u0, cu)
        `CHK("stopped outputs", 1'b0, on)
    endtask
    task t_trap;
        tpse_host_i.cmd(8'hC0, 2, 16'h0010);
        ticks(8);
        `CHK("on before trap", 1'b1, on)
        trap_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK("trap phase", 3'h3, ph_out)
        `CHK("trap complement", 3'h5, co_out)
        @(posedge clk);
        trap_n <= 1'b1;
        ticks(2);
        `CHK("trap sticky", 1'b1, tact)
        do_reset;
    endtask
    initial begin
        #3_000_000;
        bad_count++;
        summarize;
    end
    initial begin
        do_reset;
        t_query;
        t_set;
        t_ramp;
        t_dir;
        t_stop;
        t_trap;
        summarize;
    end
endmodule

// File: tb/tpse_engine_properties.sv
// concurrent checks on the ports of the sine pwm engine
`timescale 1ns/1ps
module tpse_props (
    input wire CLK,
    input wire NRST,
    input wire UPDATE_TICK,
    input wire TX_READY,
    input wire TX_VALID,
    input wire [7:0] TX_DATA,
    input wire TRAP_INPUT_N,
    input wire [5:0] TRAP_ENABLE_REG,
    input wire [2:0] TRAP_LEVEL_REG,
    input wire [2:0] PWM_PHASE_IN,
    input wire [2:0] PWM_PHASE_OUT,
    input wire [2:0] PWM_COMPLEMENT_OUT,
    input wire [7:0] CMP_U,
    input wire [7:0] CMP_V,
    input wire [7:0] CMP_W,
    input wire CMP_LOAD,
    input wire OUTPUTS_ON,
    input wire TRAP_ACTIVE,
    input wire TABLE_READY
);
    logic [3:0] busy_reg;
    logic [1:0] quiet_reg;
    // busy: update sequence in flight; quiet: trap pin high for three edges
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            busy_reg <= 4'h0;
            quiet_reg <= 2'h0;
        end else begin
            if (UPDATE_TICK && TABLE_READY && busy_reg == 4'h0) busy_reg <= 4'h7;
            else if (busy_reg != 4'h0) busy_reg <= busy_reg - 4'h1;
            if (!TRAP_INPUT_N) quiet_reg <= 2'h0;
            else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    a_load_timing: assert property (
        UPDATE_TICK && TABLE_READY && busy_reg == 4'h0 && !TRAP_ACTIVE |-> ##8 CMP_LOAD)
        else $error("compare load not eight cycles after tick");
    a_load_cause: assert property (CMP_LOAD |-> $past(UPDATE_TICK, 8))
        else $error("compare load without tick");
    a_load_pulse: assert property (CMP_LOAD |=> !CMP_LOAD)
        else $error("compare load longer than one cycle");
    a_cmp_hold: assert property (!CMP_LOAD |-> $stable({CMP_U, CMP_V, CMP_W}))
        else $error("compare value changed without load");
    a_cmp_range: assert property (CMP_LOAD |-> CMP_U >= 8'h14 && CMP_U <= 8'hFA
        && CMP_V >= 8'h14 && CMP_V <= 8'hFA && CMP_W >= 8'h14 && CMP_W <= 8'hFA)
        else $error("compare value out of range");
    a_off_zero: assert property (
        (!OUTPUTS_ON && quiet_reg == 2'h3 && TRAP_INPUT_N) ##1 (!OUTPUTS_ON && !TRAP_ACTIVE)
        |-> PWM_PHASE_OUT == 3'h0 && PWM_COMPLEMENT_OUT == 3'h0)
        else $error("outputs driven while off");
    a_on_pass: assert property (
        (OUTPUTS_ON && quiet_reg == 2'h3 && TRAP_INPUT_N) ##1 (OUTPUTS_ON && !TRAP_ACTIVE)
        |-> PWM_PHASE_OUT == $past(PWM_PHASE_IN))
        else $error("phase output does not follow input");
    a_trap_sets: assert property (!TRAP_INPUT_N [*3] |=> ##1 TRAP_ACTIVE)
        else $error("trap flag not set");
    a_trap_force: assert property (TRAP_ACTIVE && $past(TRAP_ACTIVE) |->
        ((PWM_PHASE_OUT ^ TRAP_LEVEL_REG) & TRAP_ENABLE_REG[2:0]) == 3'h0
        && ((PWM_COMPLEMENT_OUT ^ TRAP_LEVEL_REG) & TRAP_ENABLE_REG[5:3]) == 3'h0)
        else $error("trap level not applied");
    a_trap_sticky: assert property (TRAP_ACTIVE |=> TRAP_ACTIVE)
        else $error("trap flag cleared without reset");
    a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("reply byte dropped before accept");
endmodule
bind tpse_engine tpse_props tpse_props_i (.CLK(CLK), .NRST(NRST), .UPDATE_TICK(UPDATE_TICK),
    .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TRAP_INPUT_N(TRAP_INPUT_N),
    .TRAP_ENABLE_REG(TRAP_ENABLE_REG), .TRAP_LEVEL_REG(TRAP_LEVEL_REG),
    .PWM_PHASE_IN(PWM_PHASE_IN), .PWM_PHASE_OUT(PWM_PHASE_OUT),
    .PWM_COMPLEMENT_OUT(PWM_COMPLEMENT_OUT), .CMP_U(CMP_U), .CMP_V(CMP_V), .CMP_W(CMP_W),
    .CMP_LOAD(CMP_LOAD), .OUTPUTS_ON(OUTPUTS_ON), .TRAP_ACTIVE(TRAP_ACTIVE),
    .TABLE_READY(TABLE_READY));

// File: tb/tpse_host.sv
// host model for the byte command link of the sine pwm engine
`timescale 1ns/1ps
module tpse_host (
    input wire CLK,
    output logic RX_VALID,
    output logic [7:0] RX_DATA,
    output logic TX_READY,
    input wire TX_VALID,
    input wire [7:0] TX_DATA
);
    int lag = 0;
    initial begin
        RX_VALID = 1'b0;
        RX_DATA = 8'h00;
        TX_READY = 1'b0;
    end
    // released data line shows the inverse of the last byte
    task send(input logic [7:0] b);
        @(posedge CLK);
        RX_VALID <= 1'b1;
        RX_DATA <= b;
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_DATA <= ~b;
        @(posedge CLK);
    endtask
    // command byte, then its argument bytes low byte first
    task cmd(input logic [7:0] c, input int n, input logic [15:0] arg);
        send(c);
        if (n > 0) send(arg[7:0]);
        if (n > 1) send(arg[15:8]);
    endtask
    // waits for an offered byte, stalls lag cycles, then takes it
    task recv(output logic [7:0] b);
        int i;
        i = 0;
        @(negedge CLK);
        while (TX_VALID !== 1'b1 && i < 40) begin
            @(negedge CLK);
            i++;
        end
        repeat (lag) @(posedge CLK);
        @(posedge CLK);
        TX_READY <= 1'b1;
        @(negedge CLK);
        b = TX_DATA;
        @(posedge CLK);
        TX_READY <= 1'b0;
    endtask
endmodule
